/* verilog/ipfb_top.v */
// priority field bank: AXI4-Lite register plus per-source request gating
//
// The implementer's own choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ns
`include "ipfb_regs.vh"
module ipfb_top #(
   parameter SOURCES = 4
) (
   input wire mclk,
   input wire reset_n,
   input wire [`IPFB_ADDR_W-1:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [`IPFB_ADDR_W-1:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire [SOURCES-1:0] source_pending,
   output reg [15:0] priority_fields,
   output reg [SOURCES-1:0] irq_request,
   output reg [3*SOURCES-1:0] irq_level
);
   reg [15:0] prio;
   reg aw_held;
   reg w_held;
   reg [`IPFB_ADDR_W-1:0] aw_addr;
   reg [31:0] w_data;
   reg [3:0] w_strb;
   wire [SOURCES-1:0] gated_req;
   wire [3*SOURCES-1:0] gated_lvl;
   wire [15:0] next_prio;
   wire do_write;
   wire [15:0] status_word;

   // order: external zero, capture one, compare one, timer one (field i at bits 4i+2..4i)
   assign do_write = aw_held & w_held & ~s_axi_bvalid;
   assign next_prio = {
      w_strb[1] ? w_data[15:8] : prio[15:8],
      w_strb[0] ? w_data[7:0] : prio[7:0]
   } & `IPFB_PRIO_MASK;

   // latched request bits, so software can watch live state
   assign status_word = {{(16 - SOURCES){1'b0}}, irq_request};

   // AXI write channel: address and data accepted in either order
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= {`IPFB_ADDR_W{1'b0}};
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `IPFB_RESP_OKAY;
         prio <= `IPFB_PRIO_RESET;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (do_write) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            if (aw_addr[`IPFB_ADDR_W-1:2] == `IPFB_PRIO_OFFSET >> 2) begin
               prio <= next_prio;
               s_axi_bresp <= `IPFB_RESP_OKAY;
            end else if (aw_addr[`IPFB_ADDR_W-1:2] == `IPFB_STATUS_OFFSET >> 2) begin
               // status is read-only; write ignored
               s_axi_bresp <= `IPFB_RESP_OKAY;
            end else begin
               s_axi_bresp <= `IPFB_RESP_SLVERR;
            end
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // AXI read channel: one read under way at a time
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `IPFB_RESP_OKAY;
      end else begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            if (s_axi_araddr[`IPFB_ADDR_W-1:2] == `IPFB_PRIO_OFFSET >> 2) begin
               // gap bits held zero by the write mask
               s_axi_rdata <= {16'h0000, prio};
               s_axi_rresp <= `IPFB_RESP_OKAY;
            end else if (s_axi_araddr[`IPFB_ADDR_W-1:2] == `IPFB_STATUS_OFFSET >> 2) begin
               s_axi_rdata <= {16'h0000, status_word};
               s_axi_rresp <= `IPFB_RESP_OKAY;
            end else begin
               s_axi_rdata <= 32'h00000000;
               s_axi_rresp <= `IPFB_RESP_SLVERR;
            end
         end
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

   genvar s;
   generate
      for (s = 0; s < SOURCES; s = s + 1) begin : g_src
         ipfb_source_gate u_gate (
            .mclk(mclk),
            .reset_n(reset_n),
            .field(prio[4*s+2:4*s]),
            .pending(source_pending[s]),
            .request(gated_req[s]),
            .request_level(gated_lvl[3*s+2:3*s])
         );
      end
   endgenerate

   // register outputs once more so every top output is a flip-flop
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         priority_fields <= `IPFB_PRIO_RESET;
         irq_request <= {SOURCES{1'b0}};
         irq_level <= {3*SOURCES{1'b0}};
      end else begin
         priority_fields <= prio;
         irq_request <= gated_req;
         irq_level <= gated_lvl;
      end
   end
endmodule

/* verilog/ipfb_regs.vh */
// register offsets, field positions, reset values and codes for the priority field bank
`ifndef IPFB_REGS_VH
`define IPFB_REGS_VH

`define IPFB_ADDR_W 4
`define IPFB_PRIO_OFFSET 4'h0
`define IPFB_STATUS_OFFSET 4'h4
`define IPFB_TIMER_ONE_LSB 12
`define IPFB_COMPARE_ONE_LSB 8
`define IPFB_CAPTURE_ONE_LSB 4
`define IPFB_EXT_ZERO_LSB 0
`define IPFB_FIELD_W 3
`define IPFB_PRIO_RESET 16'h4444
`define IPFB_PRIO_MASK 16'h7777
`define IPFB_LEVEL_OFF 3'h0
`define IPFB_LEVEL_LOW 3'h1
`define IPFB_LEVEL_HIGH 3'h7
`define IPFB_RESP_OKAY 2'h0
`define IPFB_RESP_SLVERR 2'h2

`endif

/* verilog/ipfb_level_decode.v */
// decodes one priority field into an enable and a one-hot level
`timescale 1ns/1ns
`include "ipfb_regs.vh"
module ipfb_level_decode (
   input wire [2:0] field,
   output wire source_enabled,
   output wire [7:1] level_onehot
);
   // zero disables the source entirely
   assign source_enabled = (field != `IPFB_LEVEL_OFF);
   genvar lv;
   generate
      for (lv = 1; lv < 8; lv = lv + 1) begin : g_lvl
         // field value equals level: 001 lowest, 111 highest
         localparam [2:0] LEVEL = lv;
         assign level_onehot[lv] = (field == LEVEL);
      end
   endgenerate
endmodule

/* verilog/ipfb_source_gate.v */
// gates one pending source by its priority level
`timescale 1ns/1ns
`include "ipfb_regs.vh"
module ipfb_source_gate (
   input wire mclk,
   input wire reset_n,
   input wire [2:0] field,
   input wire pending,
   output reg request,
   output reg [2:0] request_level
);
   wire enabled;
   wire [7:1] onehot;
   reg [2:0] next_level;
   integer k;

   ipfb_level_decode u_dec (
      .field(field),
      .source_enabled(enabled),
      .level_onehot(onehot)
   );

   always @* begin
      next_level = `IPFB_LEVEL_OFF;
      for (k = 1; k < 8; k = k + 1) begin
         if (onehot[k]) begin
            next_level = k[2:0];
         end
      end
   end

   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         request <= 1'b0;
         request_level <= 3'h0;
      end else begin
         // a disabled source never reaches the core
         request <= pending & enabled;
         request_level <= (pending & enabled) ? next_level : `IPFB_LEVEL_OFF;
      end
   end
endmodule

/* testbench/ipfb_chk.sv */
// port checker for the priority field bank
`timescale 1ns/1ns
`include "ipfb_regs.vh"
module ipfb_chk #(parameter SOURCES = 4) (
   input wire mclk, reset_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
   input wire s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid,
   input wire [31:0] s_axi_rdata,
   input wire [3:0] s_axi_araddr,
   input wire [15:0] priority_fields,
   input wire [SOURCES-1:0] irq_request,
   input wire [3*SOURCES-1:0] irq_level
);
   // status reads carry live request bits, so the gap check needs the read address
   reg [3:0] rd_addr;
   always @(posedge mclk) begin
      if (s_axi_arvalid && s_axi_arready) begin
         rd_addr <= s_axi_araddr;
      end
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (!reset_n);
   sequence wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence rd_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   a_write_answer: assert property (wr_taken |=> !s_axi_awready ##1 s_axi_bvalid)
      else $error("write response missing");
   a_read_answer: assert property (rd_taken |=> s_axi_rvalid && !s_axi_arready)
      else $error("read response missing");
   a_resp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped early");
   a_reserved_zero: assert property ((priority_fields & 16'h8888) == 16'h0000)
      else $error("reserved field bit set");
   a_read_reserved: assert property (s_axi_rvalid && rd_addr[3:2] == 2'h0 |->
      (s_axi_rdata & 32'hFFFF8888) == 32'h0) else $error("reserved read bit set");
   a_timer_level: assert property (irq_request[3] && $stable(priority_fields) |->
      irq_level[11:9] == priority_fields[14:12]) else $error("timer level wrong");
   a_compare_level: assert property (irq_request[2] && $stable(priority_fields) |->
      irq_level[8:6] == priority_fields[10:8]) else $error("compare level wrong");
   a_off_no_request: assert property (irq_request[0] |-> irq_level[2:0] != `IPFB_LEVEL_OFF)
      else $error("request at level zero");
   a_idle_level: assert property (!irq_request[1] |-> irq_level[5:3] == 3'h0)
      else $error("level without request");
endmodule
bind ipfb_top ipfb_chk #(.SOURCES(SOURCES)) i_ipfb_chk (.*);

/* testbench/testbench.sv */
// self-checking bench for the priority field bank
`timescale 1ns/1ns
`include "ipfb_regs.vh"
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_errors++; \
   $display("unexpected at %0t: %h vs %h", $time, a, b); end end
module testbench;
   logic mclk = 0, reset_n = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic s_axi_arready, s_axi_rvalid;
   logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 0, source_pending = 0;
   logic [3:0] irq_request;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
   logic [1:0] s_axi_bresp, s_axi_rresp, rs;
   logic [15:0] priority_fields, cur, v;
   logic [11:0] irq_level;
   int n_errors = 0, checks = 0, i, seed;
   ipfb_top i_ipfb_top (.*);
   always #50 mclk = ~mclk;
   task wr(input [3:0] a, input [31:0] d, input [3:0] s, output [1:0] r);
      @(posedge mclk);
      s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_wstrb <= s;
      s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
      do begin
         @(posedge mclk);
         if (s_axi_awready) s_axi_awvalid <= 0;
         if (s_axi_wready) s_axi_wvalid <= 0;
      end while (!s_axi_bvalid);
      r = s_axi_bresp;
      s_axi_bready <= 0;
   endtask
   task rdt(input [3:0] a, output [31:0] d, output [1:0] r);
      @(posedge mclk);
      s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
      do begin
         @(posedge mclk);
         if (s_axi_arready) s_axi_arvalid <= 0;
      end while (!s_axi_rvalid);
      d = s_axi_rdata; r = s_axi_rresp;
      s_axi_rready <= 0;
   endtask
   // merged strobe effect, unused bits masked off
   function [15:0] merge(input [15:0] c, input [15:0] d, input [3:0] s);
      merge = {s[1] ? d[15:8] : c[15:8], s[0] ? d[7:0] : c[7:0]} & `IPFB_PRIO_MASK;
   endfunction
   function [15:0] expect_irq(input [15:0] f, input [3:0] p);
      int k;
      expect_irq = 0;
      for (k = 0; k < 4; k++) if (p[k] && f[4*k+:3] != 0) begin
         expect_irq[k] = 1;
         expect_irq[4+3*k+:3] = f[4*k+:3];
      end
   endfunction
   task conclude;
      if (n_errors == 0 && checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   initial begin
      #1000000;
      n_errors++;
      conclude;
   end
   initial begin
      seed = $urandom(1305);
      repeat (20) @(posedge mclk);
      reset_n <= 1;
      rdt(`IPFB_PRIO_OFFSET, rd, rs);
      `CHK(rd, {16'h0, `IPFB_PRIO_RESET})
      cur = `IPFB_PRIO_RESET;
      for (i = 0; i < 24; i++) begin
         // corner values first: all off, all highest, all lowest
         v = i == 0 ? 16'h0000 : i == 1 ? 16'hFFFF : i == 2 ? 16'h1111 : $urandom;
         source_pending <= i < 3 ? 4'hF : $urandom;
         wr(`IPFB_PRIO_OFFSET, {$urandom, v}, i < 3 ? 4'hF : $urandom, rs);
         `CHK(rs, `IPFB_RESP_OKAY)
         cur = merge(cur, v, i < 3 ? 4'hF : s_axi_wstrb);
         rdt(`IPFB_PRIO_OFFSET, rd, rs);
         `CHK(rd, {16'h0, cur})
         repeat (3) @(posedge mclk);
         `CHK({irq_level, irq_request}, expect_irq(cur, source_pending))
         `CHK(priority_fields, cur)
         rdt(`IPFB_STATUS_OFFSET, rd, rs);
         `CHK(rd, {16'h0, expect_irq(cur, source_pending) & 16'h000F})
      end
      wr(4'h8, 32'hFFFFFFFF, 4'hF, rs);
      `CHK(rs, `IPFB_RESP_SLVERR)
      rdt(4'h8, rd, rs);
      `CHK({rs, rd}, {`IPFB_RESP_SLVERR, 32'h0})
      rdt(`IPFB_PRIO_OFFSET, rd, rs);
      `CHK(rd, {16'h0, cur})
      conclude;
   end
endmodule
